// [hdl/pcg_gate_bank.sv]
// Gate register bank: six masked registers with alias writes and lock
`timescale 1ns/10ps
module pcg_gate_bank
  import pcg_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Write port
  pcg_wr_if.bank wr,
  input wire logic locked_i,
  // Register contents
  output logic [31:0] regs_o [PCG_NREG]
);
  import pcg_pkg::*;

  // ---------------------------------------------------------------
  // Alias write arithmetic
  // ---------------------------------------------------------------
  function automatic logic [31:0] pcg_apply(input logic [31:0] cur, input logic [31:0] wd,
                                           input logic [3:0] al, input logic [31:0] msk);
    logic [31:0] nv;
    nv = cur;
    case (al)
      PCG_ALIAS_PLAIN: nv = wd;
      PCG_ALIAS_CLR: nv = cur & ~wd;
      PCG_ALIAS_SET: nv = cur | wd;
      PCG_ALIAS_INV: nv = cur ^ wd;
      default: nv = cur;
    endcase
    return nv & msk;
  endfunction

  localparam logic [31:0] MASKS [PCG_NREG] = '{PCG_MASK_ANALOG, PCG_MASK_COMP,
    PCG_MASK_CAPCMP, PCG_MASK_TIMERS, PCG_MASK_SERIAL, PCG_MASK_MISC};
  localparam logic [15:0] BASES [PCG_NREG] = '{PCG_OFS_ANALOG, PCG_OFS_COMP,
    PCG_OFS_CAPCMP, PCG_OFS_TIMERS, PCG_OFS_SERIAL, PCG_OFS_MISC};

  wire logic [31:0] byte_mask = {{8{wr.strb[3]}}, {8{wr.strb[2]}}, {8{wr.strb[1]}},
                                 {8{wr.strb[0]}}};

  // Each register sees only writes to its own 16 byte window
  for (genvar g = 0; g < PCG_NREG; g++)
  begin : g_reg
    wire logic hit = wr.strobe && !locked_i && (wr.addr[15:4] == BASES[g][15:4]);
    wire logic [31:0] wd = wr.data & byte_mask;
    wire logic [31:0] keep = regs_o[g] & ~byte_mask;
    wire logic [31:0] applied = pcg_apply(regs_o[g], wd, wr.addr[3:0], MASKS[g]);
    // Plain writes keep bytes not strobed; alias writes use zero there
    wire logic [31:0] next_val = (wr.addr[3:0] == PCG_ALIAS_PLAIN) ?
                                 ((applied | keep) & MASKS[g]) : applied;
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
        regs_o[g] <= PCG_RESET_VAL;
      else if (hit)
        regs_o[g] <= next_val;
    end
  end
endmodule

// [hdl/pcg_pkg.sv]
// Package: register map, field layout and constants of the clock gate bank
// How it works
// - With one-time lock set, write-lock cannot be cleared once set.
// - While write-lock is set, unlock and protected register writes are refused; here a lock word write of zero still clears it unless one-time lock engaged.
// - After one-time lock engages, only a device reset clears write-lock.
// - Offsets 0x4, 0x8, 0xC clear, set or invert the written one bits.
// - Unimplemented gate bits read zero and ignore writes.
// - Comparators three, two, one gate at bits 2, 1, 0 of register two.
// - Compare units five to one gate at bits 20 down to 16.
// - Capture units five to one gate at bits 4 down to 0.
// - Calendar bit 0, reference clock out bit 1, parallel port bit 16.
// - Gate bit one stops the module clock; zero, the default, runs it.
// - Locked gate register writes answer OKAY but change nothing.
// - Gated modules ignore control writes; their reads are undefined.
package pcg_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int PCG_ADDR_W = 16;
  localparam logic [15:0] PCG_OFS_ANALOG = 16'hf240;
  localparam logic [15:0] PCG_OFS_COMP = 16'hf250;
  localparam logic [15:0] PCG_OFS_CAPCMP = 16'hf260;
  localparam logic [15:0] PCG_OFS_TIMERS = 16'hf270;
  localparam logic [15:0] PCG_OFS_SERIAL = 16'hf280;
  localparam logic [15:0] PCG_OFS_MISC = 16'hf290;
  localparam logic [15:0] PCG_OFS_LOCK = 16'hf2a0;
  localparam logic [3:0] PCG_ALIAS_PLAIN = 4'h0;
  localparam logic [3:0] PCG_ALIAS_CLR = 4'h4;
  localparam logic [3:0] PCG_ALIAS_SET = 4'h8;
  localparam logic [3:0] PCG_ALIAS_INV = 4'hc;
  localparam int PCG_NREG = 6;
  // ---------------------------------------------------------------
  // Field layout: implemented bit masks
  // ---------------------------------------------------------------
  localparam logic [31:0] PCG_MASK_ANALOG = 32'h0000_1101;
  localparam logic [31:0] PCG_MASK_COMP = 32'h0000_0007;
  localparam logic [31:0] PCG_MASK_CAPCMP = 32'h001f_001f;
  localparam logic [31:0] PCG_MASK_TIMERS = 32'h0000_001f;
  localparam logic [31:0] PCG_MASK_SERIAL = 32'h0003_0303;
  localparam logic [31:0] PCG_MASK_MISC = 32'h0001_0003;
  localparam int PCG_LOCK_BIT = 0;
  localparam int PCG_ONE_TIME_BIT = 1;
  localparam logic [31:0] PCG_RESET_VAL = 32'h0000_0000;
  // ---------------------------------------------------------------
  // Bus answers
  // ---------------------------------------------------------------
  localparam logic [1:0] PCG_RESP_OKAY = 2'b00;
  localparam logic [1:0] PCG_RESP_SLVERR = 2'b10;
endpackage

// [hdl/pcg_top.sv]
// Top: AXI4-Lite slave, write lock and per-module clock gate outputs
`timescale 1ns/10ps
module pcg_top
  import pcg_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // One-time lock configuration strap
  input wire logic gate_lock_one_time_i,
  // AXI4-Lite write address and data
  input wire logic [PCG_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read
  input wire logic [PCG_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Clock gate outputs, high stops the module clocks
  output logic [2:0] analog_gate_o,
  output logic [2:0] comparator_gate_o,
  output logic [4:0] capture_gate_o,
  output logic [4:0] compare_gate_o,
  output logic [4:0] timer_gate_o,
  output logic [1:0] async_serial_gate_o,
  output logic [1:0] sync_serial_gate_o,
  output logic [1:0] i2c_gate_o,
  output logic calendar_gate_o,
  output logic ref_clock_out_gate_o,
  output logic parallel_port_gate_o,
  // Lock state
  output logic gate_write_lock_o
);
  import pcg_pkg::*;

  // ---------------------------------------------------------------
  // Strap capture
  // ---------------------------------------------------------------
  logic strap_meta;
  logic strap_sync;
  logic one_time;
  logic gate_write_lock;
  logic lock_seen;

  // Strap is external, so it crosses two flops before use
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      strap_meta <= 1'b0;
      strap_sync <= 1'b0;
    end
    else
    begin
      strap_meta <= gate_lock_one_time_i;
      strap_sync <= strap_meta;
    end
  end

  // Latch the strap once it has crossed both sync flops; taking it earlier
  // would only ever see the reset value of the synchroniser
  logic strap_taken;
  logic [1:0] strap_age;
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      strap_taken <= 1'b0;
      strap_age <= 2'b00;
      one_time <= 1'b0;
    end
    else
    begin
      strap_age <= {strap_age[0], 1'b1};
      if (strap_age[1] && !strap_taken)
      begin
        strap_taken <= 1'b1;
        one_time <= strap_sync;
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [15:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [1:0] bresp;
  logic bvalid;

  wire logic aw_take = s_axi_awvalid_i && s_axi_awready_o;
  wire logic w_take = s_axi_wvalid_i && s_axi_wready_o;
  wire logic wr_fire = aw_held && w_held && !bvalid;
  wire logic [15:0] wr_addr = aw_addr;

  assign s_axi_awready_o = !aw_held && !bvalid;
  assign s_axi_wready_o = !w_held && !bvalid;

  // Address and data may arrive in either order
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 16'h0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      else if (wr_fire)
        aw_held <= 1'b0;
      if (w_take)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      else if (wr_fire)
        w_held <= 1'b0;
    end
  end

  // Decode: bank windows, lock register word, else unmapped
  wire logic wr_in_bank = (wr_addr >= PCG_OFS_ANALOG) && (wr_addr < PCG_OFS_LOCK)
                          && (wr_addr[1:0] == 2'b00);
  wire logic wr_is_lock = (wr_addr == PCG_OFS_LOCK);
  wire logic wr_mapped = wr_in_bank || wr_is_lock;

  // Locked writes still answer OKAY so software sees nothing odd
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bvalid <= 1'b0;
      bresp <= PCG_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid <= 1'b1;
      bresp <= wr_mapped ? PCG_RESP_OKAY : PCG_RESP_SLVERR;
    end
    else if (s_axi_bready_i)
      bvalid <= 1'b0;
  end
  assign s_axi_bvalid_o = bvalid;
  assign s_axi_bresp_o = bresp;

  // ---------------------------------------------------------------
  // Write lock
  // ---------------------------------------------------------------
  // The unlock key sequence lives elsewhere; here a direct write of the
  // lock word stands for it. Once set under one-time mode it sticks.
  wire logic lock_wr = wr_fire && wr_is_lock && w_strb[0];
  wire logic lock_clear_refused = one_time && lock_seen;
  wire logic next_lock = lock_wr ?
    (w_data[PCG_LOCK_BIT] || lock_clear_refused) : gate_write_lock;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      gate_write_lock <= 1'b0;
      lock_seen <= 1'b0;
    end
    else
    begin
      gate_write_lock <= next_lock;
      if (next_lock)
        lock_seen <= 1'b1;
    end
  end
  assign gate_write_lock_o = gate_write_lock;

  // ---------------------------------------------------------------
  // Gate register bank
  // ---------------------------------------------------------------
  pcg_wr_if bank_wr ();
  logic [31:0] regs [PCG_NREG];

  assign bank_wr.strobe = wr_fire && wr_in_bank;
  assign bank_wr.addr = wr_addr;
  assign bank_wr.data = w_data;
  assign bank_wr.strb = w_strb;

  pcg_gate_bank u_bank (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .wr(bank_wr),
    .locked_i(gate_write_lock),
    .regs_o(regs)
  );

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;

  assign s_axi_arready_o = !rvalid;
  wire logic ar_take = s_axi_arvalid_i && s_axi_arready_o;
  wire logic [15:0] rd_addr = s_axi_araddr_i;
  wire logic rd_in_bank = (rd_addr >= PCG_OFS_ANALOG) && (rd_addr < PCG_OFS_LOCK)
                          && (rd_addr[1:0] == 2'b00);
  wire logic [2:0] rd_idx = 3'(rd_addr[6:4] - 3'd4);
  // Alias words read back the register value too
  wire logic [31:0] rd_bank = regs[rd_idx];
  wire logic [31:0] rd_lock = {30'h0, one_time, gate_write_lock};
  wire logic rd_mapped = rd_in_bank || (rd_addr == PCG_OFS_LOCK);

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= PCG_RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid <= 1'b1;
      rdata <= rd_in_bank ? rd_bank : (rd_mapped ? rd_lock : 32'h0000_0000);
      rresp <= rd_mapped ? PCG_RESP_OKAY : PCG_RESP_SLVERR;
    end
    else if (s_axi_rready_i)
      rvalid <= 1'b0;
  end
  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rdata_o = rdata;
  assign s_axi_rresp_o = rresp;

  // ---------------------------------------------------------------
  // Gate outputs
  // ---------------------------------------------------------------
  // Straight from the bank flops: a high stops the module clocks, and a
  // gated module then ignores its own register writes
  assign analog_gate_o = {regs[0][12], regs[0][8], regs[0][0]};
  assign comparator_gate_o = regs[1][2:0];
  assign compare_gate_o = regs[2][20:16];
  assign capture_gate_o = regs[2][4:0];
  assign timer_gate_o = regs[3][4:0];
  assign async_serial_gate_o = regs[4][1:0];
  assign sync_serial_gate_o = regs[4][9:8];
  assign i2c_gate_o = regs[4][17:16];
  assign calendar_gate_o = regs[5][0];
  assign ref_clock_out_gate_o = regs[5][1];
  assign parallel_port_gate_o = regs[5][16];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_lock_engaged;
    one_time && lock_seen;
  endsequence
  sequence s_lock_clear_try;
    lock_wr && !w_data[PCG_LOCK_BIT];
  endsequence

  AST_ONE_TIME_STICKS: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_lock_engaged ##0 s_lock_clear_try |=> gate_write_lock)
    else $error("one-time lock was cleared");
  AST_LOCK_FREEZES: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    gate_write_lock |=> $stable(regs[3]) && $stable(regs[5]))
    else $error("gate register changed while locked");
  AST_NO_RELEASE: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_lock_engaged |=> gate_write_lock)
    else $error("lock dropped without reset");
  AST_SET_ALIAS: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    bank_wr.strobe && !gate_write_lock && wr_addr == (PCG_OFS_TIMERS | 16'h0008)
    && w_strb == 4'hf |=> regs[3] == (($past(regs[3]) | $past(w_data)) & PCG_MASK_TIMERS))
    else $error("set alias wrong");
  AST_CLR_ALIAS: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    bank_wr.strobe && !gate_write_lock && wr_addr == (PCG_OFS_MISC | 16'h0004)
    && w_strb == 4'hf |=> regs[5] == ($past(regs[5]) & ~$past(w_data)))
    else $error("clear alias wrong");
  AST_RESERVED_ZERO: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (regs[2] & ~PCG_MASK_CAPCMP) == 32'h0 && (regs[4] & ~PCG_MASK_SERIAL) == 32'h0)
    else $error("unimplemented bit set");
  AST_LOCKED_OKAY: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_fire && wr_in_bank |=> s_axi_bvalid_o && s_axi_bresp_o == PCG_RESP_OKAY)
    else $error("bank write not answered OKAY");
  AST_GATE_FOLLOWS: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    bank_wr.strobe && !gate_write_lock && wr_addr == PCG_OFS_COMP && w_strb[0]
    |=> comparator_gate_o == $past(w_data[2:0]))
    else $error("gate output did not follow write");
endmodule

// [hdl/pcg_wr_if.sv]
// Interface: accepted register write from the bus slave to the bank
`timescale 1ns/10ps
interface pcg_wr_if;
  logic strobe;
  logic [15:0] addr;
  logic [31:0] data;
  logic [3:0] strb;
  modport master (output strobe, output addr, output data, output strb);
  modport bank (input strobe, input addr, input data, input strb);
endinterface

// [verification/tb_top.sv]
// Testbench: self-checking AXI4-Lite tests of the clock gate bank
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module tb_top;
  import pcg_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk_sys_i, rst_n_i, strap;
  logic [15:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, lock;
  logic [1:0] bresp, rresp;
  logic [2:0] an_g, cmp_g;
  logic [4:0] cap_g, oc_g, tmr_g;
  logic [1:0] as_g, ss_g, i2c_g;
  logic cal_g, ref_g, pp_g;
  int miscompares, total_checks;
  // ---------------------------------------------------------------
  // Device under test
  // ---------------------------------------------------------------
  pcg_top dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .gate_lock_one_time_i(strap),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .analog_gate_o(an_g),
    .comparator_gate_o(cmp_g), .capture_gate_o(cap_g), .compare_gate_o(oc_g),
    .timer_gate_o(tmr_g), .async_serial_gate_o(as_g), .sync_serial_gate_o(ss_g),
    .i2c_gate_o(i2c_g), .calendar_gate_o(cal_g), .ref_clock_out_gate_o(ref_g),
    .parallel_port_gate_o(pp_g), .gate_write_lock_o(lock)
  );
  // Clock, 5 ns period
  initial
  begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  // Write: address and data offered together, each released when taken.
  // Handshakes are judged mid-cycle, where the slave outputs have settled,
  // and acted on at the next rising edge, which is the sampling edge.
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    bit aw, w, b, aw_now, w_now;
    aw = 0;
    w = 0;
    b = 0;
    @(posedge clk_sys_i);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b)
    begin
      @(negedge clk_sys_i);
      b = (bvalid === 1'b1);
      if (b)
        `CHK(bresp, er)
      aw_now = !aw && (awready === 1'b1);
      w_now = !w && (wready === 1'b1);
      @(posedge clk_sys_i);
      if (aw_now)
      begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (w_now)
      begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b0;
  endtask
  // Read: hold request until taken, rready until the answer is seen
  task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit ar, r, ar_now;
    ar = 0;
    r = 0;
    @(posedge clk_sys_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r)
    begin
      @(negedge clk_sys_i);
      r = (rvalid === 1'b1);
      if (r)
      begin
        `CHK(rdata, ed)
        `CHK(rresp, er)
      end
      ar_now = !ar && (arready === 1'b1);
      @(posedge clk_sys_i);
      if (ar_now)
      begin
        ar = 1;
        arvalid <= 1'b0;
      end
    end
    rready <= 1'b0;
  endtask
  // Reset pulse; strap must already be stable when it ends
  task automatic do_reset();
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // All gate registers, the lock and every gate output but i2c_g are checked cleared at start
  task automatic t_reset_vals();
    for (int i = 0; i < PCG_NREG; i++)
      rd(PCG_OFS_ANALOG + 16'(i * 16), PCG_RESET_VAL, PCG_RESP_OKAY);
    `CHK({an_g, cmp_g, cap_g, oc_g, tmr_g, as_g, ss_g, cal_g, ref_g, pp_g, lock}, 29'h0)
  endtask
  // One bit per field, I2C and calendar excepted, lands on the matching gate output; the bench has no
  // module enables, so every gated module counts as already switched off
  task automatic t_fields();
    wr(PCG_OFS_COMP, 32'h4, 4'hf, PCG_RESP_OKAY);
    `CHK(cmp_g, 3'b100)
    wr(PCG_OFS_CAPCMP, 32'h0010_0001, 4'hf, PCG_RESP_OKAY);
    `CHK(oc_g, 5'b10000)
    `CHK(cap_g, 5'b00001)
    wr(PCG_OFS_TIMERS, 32'h0001_0010, 4'hf, PCG_RESP_OKAY);
    `CHK(tmr_g, 5'b10000)
    rd(PCG_OFS_TIMERS, 32'h0000_0010, PCG_RESP_OKAY);
    wr(PCG_OFS_SERIAL, 32'h0000_0201, 4'hf, PCG_RESP_OKAY);
    `CHK({ss_g, as_g}, 4'b1001)
    wr(PCG_OFS_MISC, 32'h0001_0002, 4'hf, PCG_RESP_OKAY);
    `CHK({pp_g, ref_g, cal_g}, 3'b110)
    wr(PCG_OFS_ANALOG, 32'h0000_0100, 4'hf, PCG_RESP_OKAY);
    `CHK(an_g, 3'b010)
  endtask
  // Unimplemented bits read zero; byte strobes respected
  task automatic t_mask();
    logic [31:0] m [PCG_NREG];
    m = '{PCG_MASK_ANALOG, PCG_MASK_COMP, PCG_MASK_CAPCMP, PCG_MASK_TIMERS,
          PCG_MASK_SERIAL, PCG_MASK_MISC};
    for (int i = 0; i < PCG_NREG; i++)
    begin
      wr(PCG_OFS_ANALOG + 16'(i * 16), 32'hffff_ffff, 4'hf, PCG_RESP_OKAY);
      rd(PCG_OFS_ANALOG + 16'(i * 16), m[i], PCG_RESP_OKAY);
    end
    `CHK({an_g, cmp_g, cap_g, oc_g, tmr_g, as_g, ss_g, i2c_g, cal_g, ref_g, pp_g}, 30'h3fff_ffff)
    wr(PCG_OFS_CAPCMP, 32'h0, 4'h1, PCG_RESP_OKAY);
    rd(PCG_OFS_CAPCMP, 32'h001f_0000, PCG_RESP_OKAY);
  endtask
  // Clear, set and invert aliases on the comparator register
  task automatic t_alias();
    wr(PCG_OFS_COMP + 16'h4, 32'hffff_fffa, 4'hf, PCG_RESP_OKAY);
    rd(PCG_OFS_COMP, 32'h5, PCG_RESP_OKAY);
    wr(PCG_OFS_COMP + 16'h8, 32'h2, 4'hf, PCG_RESP_OKAY);
    rd(PCG_OFS_COMP, 32'h7, PCG_RESP_OKAY);
    wr(PCG_OFS_COMP + 16'hc, 32'hffff_ffff, 4'hf, PCG_RESP_OKAY);
    rd(PCG_OFS_COMP, 32'h0, PCG_RESP_OKAY);
    wr(PCG_OFS_COMP + 16'hc, 32'h1, 4'hf, PCG_RESP_OKAY);
    rd(PCG_OFS_COMP + 16'h4, 32'h1, PCG_RESP_OKAY);
    `CHK(cmp_g, 3'b001)
  endtask
  // Unmapped word answers with an error and zero data
  task automatic t_unmapped();
    rd(16'hf300, 32'h0, PCG_RESP_SLVERR);
    wr(16'hf300, 32'hffff_ffff, 4'hf, PCG_RESP_SLVERR);
  endtask
  // Lock blocks writes silently; without the strap it can be cleared
  task automatic t_lock();
    wr(PCG_OFS_LOCK, 32'h1, 4'hf, PCG_RESP_OKAY);
    `CHK(lock, 1'b1)
    wr(PCG_OFS_COMP, 32'h6, 4'hf, PCG_RESP_OKAY);
    rd(PCG_OFS_COMP, 32'h1, PCG_RESP_OKAY);
    wr(PCG_OFS_COMP + 16'h8, 32'h6, 4'hf, PCG_RESP_OKAY);
    rd(PCG_OFS_COMP, 32'h1, PCG_RESP_OKAY);
    `CHK(cmp_g, 3'b001)
    wr(PCG_OFS_LOCK, 32'h0, 4'hf, PCG_RESP_OKAY);
    `CHK(lock, 1'b0)
    wr(PCG_OFS_COMP, 32'h6, 4'hf, PCG_RESP_OKAY);
    rd(PCG_OFS_COMP, 32'h6, PCG_RESP_OKAY);
  endtask
  // One-time strap: lock sticks until the next reset
  task automatic t_one_time();
    strap <= 1'b1;
    do_reset();
    rd(PCG_OFS_COMP, 32'h0, PCG_RESP_OKAY);
    rd(PCG_OFS_LOCK, 32'h2, PCG_RESP_OKAY);
    wr(PCG_OFS_LOCK, 32'h1, 4'hf, PCG_RESP_OKAY);
    wr(PCG_OFS_LOCK, 32'h0, 4'hf, PCG_RESP_OKAY);
    `CHK(lock, 1'b1)
    wr(PCG_OFS_COMP, 32'h7, 4'hf, PCG_RESP_OKAY);
    rd(PCG_OFS_COMP, 32'h0, PCG_RESP_OKAY);
    do_reset();
    `CHK(lock, 1'b0)
    wr(PCG_OFS_COMP, 32'h7, 4'hf, PCG_RESP_OKAY);
    rd(PCG_OFS_COMP, 32'h7, PCG_RESP_OKAY);
  endtask
  // ---------------------------------------------------------------
  // Verdict and main sequence
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    miscompares++;
    end_of_test();
  end
  initial
  begin
    rst_n_i = 1'b0;
    strap = 1'b0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'h0;
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    t_reset_vals();
    t_fields();
    t_mask();
    t_alias();
    t_unmapped();
    t_lock();
    t_one_time();
    end_of_test();
  end
endmodule
